// File: rtl/smbus_slave.sv
// smbus slave: pointer, register file, alert response, timeout
// assumes open-drain pins resolved outside; alert_cond_i on mclk_i
// Operation
// [R01] ack own 7-bit address 1001100 in the ninth clock slot
// [R02] eighth bit gives direction: 0 write (0x98), 1 read (0x99)
// [R03] a byte is eight bits msb first plus one acknowledge bit
// [R04] data changes only with clock low; high-clock edges mean start/stop
// [R05] master ends a write with a stop during the tenth clock
// [R06] read ends with not-acknowledge then stop; device releases data line
// [R07] direction holds until the operation ends
// [R08] first written byte loads the address pointer
// [R09] a second written byte goes to the register the pointer selects
// [R10] pointer kept between operations; bare read uses current pointer
// [R11] writes of one or two bytes, reads of one data byte
// [R12] repeated start begins a new address phase without a stop
// [R13] send byte: address and pointer, both acknowledged, pointer only
// [R14] repeated start read may follow a send byte directly
// [R15] write byte: address, pointer, data, each acknowledged
// [R16] receive byte: device drives the pointed register after acking
// [R17] read byte: pointer write, repeated start, read one byte
// [R18] while alert low, ack alert response address, return own address
// [R19] arbitrate bitwise on alert response; loser releases data line
// [R20] alert stays low until status read and condition gone
// [R21] enabled timeout: 25 ms without activity releases bus, goes idle
// [R22] config_one bit 5 clear enables timeout, set disables; reset 0
// [R23] optional crc-8 packet error byte when master clocks an extra byte
// [R24] no ack for addresses other than own or live alert response
// [R25] reset clears pointer, idles interface, releases data line
`timescale 1ns/1ns
module smbus_slave
   import smbus_slave_pkg::*;
#(
   parameter int REG_COUNT      = 256,
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input  wire logic       mclk_i,       // core clock
   input  wire logic       rstn_i,       // async reset, low
   input  wire logic       ce_i,         // clock enable
   input  wire logic       scl_i,        // bus clock pin
   input  wire logic       sda_i,        // bus data pin level
   output logic            sda_o,        // data drive value
   output logic            sda_oe_n_o,   // low while pulling data low
   output logic            alert_o,      // alert drive value
   output logic            alert_oe_n_o, // low while alert asserted
   input  wire logic       alert_cond_i, // alert cause present
   input  wire logic [7:0] status_i      // status register contents
);
   localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

   logic            scl_s1, scl_s2, scl_q;
   logic            sda_s1, sda_s2, sda_q;
   bus_evt_t        evt;
   bus_st_t         st;
   logic [3:0]      bitcnt;
   logic [7:0]      shift, txsh, crc, ptr, rd_byte;
   logic [1:0]      wr_cnt;
   logic            rw, drive, is_ara, tx_cnt, mack;
   logic [7:0]      regs [REG_COUNT];
   logic            alert_act, stat_seen;
   logic [TO_W-1:0] to_cnt;
   logic            to_hit, to_en;
   logic            own_hit, ara_hit, addr_done, rx_done, rx_ack, stat_rd;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // -------------------------------------------------------
   // pin synchronisers and bus events
   // -------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_q  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_q  <= 1'b1;
      end else if (ce_i) begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_q  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_q  <= sda_s2;
      end
   end

   always_comb begin
      evt.rise  = scl_s2 & ~scl_q;
      evt.fall  = ~scl_s2 & scl_q;
      evt.start = scl_s2 & scl_q & sda_q & ~sda_s2; // R04
      evt.stop  = scl_s2 & scl_q & ~sda_q & sda_s2; // R04
   end

   assign own_hit   = (shift[7:1] == OWN_ADDR); // R01
   assign ara_hit   = (shift[7:1] == ARA_ADDR) && shift[0] && alert_act; // R18
   assign addr_done = ce_i && !to_hit && (st == ST_ADDR) && evt.fall
                      && (bitcnt == BITS_PER_BYTE);
   assign rx_done   = ce_i && !to_hit && (st == ST_RX) && evt.fall
                      && (bitcnt == BITS_PER_BYTE);
   // pointer, data, then a matching crc byte; anything more is refused
   assign rx_ack    = (wr_cnt < 2'd2) || ((wr_cnt == 2'd2) && (shift == crc)); // R11 R23
   assign rd_byte   = (ptr == STATUS_OFS) ? status_i
                      : ((int'(ptr) < REG_COUNT) ? regs[ptr] : 8'h00);
   assign stat_rd   = ce_i && !to_hit && (st == ST_ADDR_ACK) && evt.fall
                      && rw && !is_ara && (ptr == STATUS_OFS);

   // -------------------------------------------------------
   // bus protocol engine
   // -------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st     <= ST_IDLE; // R25
         drive  <= 1'b0;
         bitcnt <= 4'h0;
         shift  <= 8'h00;
         txsh   <= 8'h00;
         crc    <= 8'h00;
         wr_cnt <= 2'd0;
         rw     <= 1'b0;
         is_ara <= 1'b0;
         tx_cnt <= 1'b0;
         mack   <= 1'b0;
      end else if (ce_i) begin
         if (evt.stop || to_hit) begin
            st    <= ST_IDLE; // R05 R21
            drive <= 1'b0;
         end else if (evt.start) begin
            st     <= ST_ADDR; // R12 R14 R17
            bitcnt <= 4'h0;
            drive  <= 1'b0;
            // pec spans repeated starts, so only a fresh start clears it
            if (st == ST_IDLE) begin
               crc <= 8'h00;
            end
         end else begin
            case (st)
               ST_ADDR, ST_RX: begin
                  if (evt.rise) begin
                     shift  <= {shift[6:0], sda_s2}; // R03
                     bitcnt <= bitcnt + 4'h1;
                  end else if (evt.fall && bitcnt == BITS_PER_BYTE) begin
                     bitcnt <= 4'h0;
                     crc    <= crc8(crc, shift); // R23
                     if (st == ST_ADDR) begin
                        if (own_hit || ara_hit) begin
                           st     <= ST_ADDR_ACK; // R01
                           drive  <= 1'b1;
                           rw     <= shift[0]; // R02 R07
                           is_ara <= ara_hit;
                           wr_cnt <= 2'd0;
                           tx_cnt <= 1'b0;
                        end else begin
                           st <= ST_IGNORE; // R24
                        end
                     end else if (rx_ack) begin
                        st     <= ST_RX_ACK; // R13 R15
                        drive  <= 1'b1;
                        wr_cnt <= wr_cnt + 2'd1;
                     end else begin
                        st <= ST_IGNORE;
                     end
                  end
               end
               ST_ADDR_ACK, ST_RX_ACK: begin
                  if (evt.fall) begin
                     if (st == ST_ADDR_ACK && rw) begin
                        st    <= ST_TX; // R16
                        txsh  <= is_ara ? {OWN_ADDR, 1'b0} : rd_byte; // R18
                        drive <= is_ara ? ~OWN_ADDR[6] : ~rd_byte[7];
                     end else begin
                        st    <= ST_RX;
                        drive <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (evt.rise) begin
                     bitcnt <= bitcnt + 4'h1;
                     if (!drive && !sda_s2) begin
                        st <= ST_IGNORE; // R19
                     end
                  end else if (evt.fall) begin
                     if (bitcnt == BITS_PER_BYTE) begin
                        st     <= ST_TX_ACK;
                        drive  <= 1'b0;
                        bitcnt <= 4'h0;
                        crc    <= crc8(crc, {txsh[6:0], txsh[7]}); // R23
                     end else begin
                        // rotate, so the whole byte is back for the pec
                        txsh  <= {txsh[6:0], txsh[7]};
                        drive <= ~txsh[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (evt.rise) begin
                     mack <= ~sda_s2;
                  end else if (evt.fall) begin
                     if (mack && !tx_cnt) begin
                        st     <= ST_TX; // R23
                        tx_cnt <= 1'b1;
                        txsh   <= crc;
                        drive  <= ~crc[7];
                     end else begin
                        st <= ST_IGNORE; // R06 R11
                     end
                  end
               end
               ST_IDLE, ST_IGNORE: begin
                  drive <= 1'b0;
               end
               default: begin
                  st    <= ST_IDLE;
                  drive <= 1'b0;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------
   // pointer and register file
   // -------------------------------------------------------
   // data lands before any pec byte arrives; a bad pec is only refused
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ptr <= 8'h00; // R25
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= (i == int'(CONFIG_ONE_OFS)) ? CONFIG_ONE_RST : 8'h00; // R22
         end
      end else if (rx_done) begin
         if (wr_cnt == 2'd0) begin
            ptr <= shift; // R08 R10
         end else if (wr_cnt == 2'd1 && ptr != STATUS_OFS
                      && int'(ptr) < REG_COUNT) begin
            regs[ptr] <= shift; // R09
         end
      end
   end

   // -------------------------------------------------------
   // alert line
   // -------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         alert_act <= 1'b0;
         stat_seen <= 1'b0;
      end else if (ce_i) begin
         if (alert_cond_i) begin
            alert_act <= 1'b1;
         end else if (stat_seen || stat_rd) begin
            alert_act <= 1'b0; // R20
         end
         if (!alert_act) begin
            stat_seen <= 1'b0;
         end else if (stat_rd) begin
            stat_seen <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------
   // bus timeout
   // -------------------------------------------------------
   assign to_en  = ~regs[CONFIG_ONE_OFS][BUS_TIMEOUT_DISABLE_BIT]; // R22
   assign to_hit = to_en && (to_cnt == TO_W'(TIMEOUT_CYCLES));

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         to_cnt <= '0;
      end else if (ce_i) begin
         if (st == ST_IDLE || !to_en || |evt) begin
            to_cnt <= '0;
         end else if (!to_hit) begin
            to_cnt <= to_cnt + TO_W'(1); // R21
         end
      end
   end

   assign sda_o        = 1'b0;
   assign sda_oe_n_o   = ~drive;
   assign alert_o      = 1'b0;
   assign alert_oe_n_o = ~alert_act;

   // -------------------------------------------------------
   // checks
   // -------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_own_addr;
      addr_done && own_hit;
   endsequence
   sequence s_tx_nack;
      ce_i && !to_hit && st == ST_TX_ACK && evt.fall && !mack;
   endsequence

   chk_own_ack: assert property (s_own_addr |=> drive && st == ST_ADDR_ACK) // R01
      else $error("own address not acknowledged");
   chk_foreign_nack: assert property (addr_done && !own_hit && !ara_hit // R24
      |=> !drive && st == ST_IGNORE)
      else $error("foreign address acknowledged");
   chk_ara_ack: assert property (addr_done && ara_hit |=> is_ara && drive) // R18
      else $error("alert response not acknowledged");
   chk_ptr_load: assert property (rx_done && wr_cnt == 2'd0 // R08
      |=> ptr == $past(shift))
      else $error("pointer not loaded");
   chk_ptr_hold: assert property (!(rx_done && wr_cnt == 2'd0) // R10
      |=> ptr == $past(ptr))
      else $error("pointer changed");
   chk_reg_store: assert property (rx_done && wr_cnt == 2'd1 // R09
      && ptr == CONFIG_ONE_OFS |=> regs[CONFIG_ONE_OFS] == $past(shift))
      else $error("data byte not stored");
   chk_stop_idle: assert property (ce_i && evt.stop |=> st == ST_IDLE ##1 !drive) // R04
      else $error("stop did not idle");
   chk_rstart_addr: assert property (ce_i && evt.start && !to_hit // R12
      |=> st == ST_ADDR && bitcnt == 4'h0)
      else $error("start did not open address phase");
   chk_nack_release: assert property (s_tx_nack |=> st == ST_IGNORE && !drive) // R06
      else $error("data line held after nack");
   chk_arb_loss: assert property (ce_i && !to_hit && st == ST_TX && evt.rise // R19
      && !drive && !sda_s2 |=> st == ST_IGNORE && !drive)
      else $error("lost arbitration not released");
   chk_dir_hold: assert property ((st == ST_RX || st == ST_TX) |=> $stable(rw)) // R07
      else $error("direction changed mid operation");
   chk_timeout_idle: assert property (ce_i && to_hit |=> st == ST_IDLE && !drive) // R21
      else $error("timeout did not release bus");
endmodule

// File: rtl/smbus_slave_pkg.sv
// smbus slave constants, states and bus event carrier
// assumes a 25 MHz core clock sampling the bus pins
package smbus_slave_pkg;
   // -------------------------------------------------------
   // addresses and registers
   // -------------------------------------------------------
   localparam logic [6:0] OWN_ADDR       = 7'h4C;
   localparam logic [6:0] ARA_ADDR       = 7'h0C;
   localparam logic [7:0] CONFIG_ONE_OFS = 8'h00;
   localparam logic [7:0] CONFIG_ONE_RST = 8'h00;
   localparam int         BUS_TIMEOUT_DISABLE_BIT      = 5;
   localparam logic [7:0] STATUS_OFS     = 8'h10;
   localparam logic [7:0] CRC_POLY       = 8'h07;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   // -------------------------------------------------------
   // timing
   // -------------------------------------------------------
   localparam int CLK_HZ         = 25_000_000;
   localparam int BUS_TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYC    = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
   // -------------------------------------------------------
   // types
   // -------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_RX       = 3'b011,
      ST_RX_ACK   = 3'b100,
      ST_TX       = 3'b101,
      ST_TX_ACK   = 3'b110,
      ST_IGNORE   = 3'b111
   } bus_st_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } bus_evt_t;
endpackage

// File: tb/smbus_master_model.sv
// behavioural smbus master: start, stop, byte out, byte in
// assumes sda_i is the resolved wire with pull-up; paced by mclk_i
`timescale 1ns/1ns
module smbus_master_model (
   input  wire logic mclk_i, // core clock, paces the bus
   input  wire logic sda_i,  // resolved data line
   output logic      scl_o,  // bus clock drive
   output logic      sda_o   // data drive, 1 releases
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // one 8-cycle bit: low 5 for slave setup, high 3, sampled before fall
   task automatic bit_cyc(input logic b, output logic s);
      scl_o = 1'b0;
      w(1);
      sda_o = b;
      w(4);
      scl_o = 1'b1;
      w(3);
      s = sda_i;
   endtask
   task automatic start();
      scl_o = 1'b0;
      w(3);
      sda_o = 1'b1;
      w(3);
      scl_o = 1'b1;
      w(4);
      sda_o = 1'b0;
      w(4);
   endtask
   task automatic stop();
      scl_o = 1'b0;
      w(1);
      sda_o = 1'b0;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_o = 1'b1;
      w(4);
   endtask
   task automatic hold(input int n);
      scl_o = 1'b0;
      w(n);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
      bit_cyc(1'b1, ack);
   endtask
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
      bit_cyc(nack, s);
   endtask
endmodule

// File: tb/tb_top.sv
// testbench: smbus slave driven by a behavioural bus master
// assumes smbus_slave_pkg and smbus_master_model are compiled first
`timescale 1ns/1ns
module tb_top;
   import smbus_slave_pkg::*;
   localparam int TO_CYC = 200; // short timeout, still above scl period
   logic       mclk_i       = 1'b0;
   logic       rstn_i       = 1'b0;
   logic       alert_cond_i = 1'b0;
   logic [7:0] status_i     = 8'h00;
   logic       scl_m, sda_m, sda_w, sda_d, sda_oe_n, alert_d, alert_oe_n;
   logic [7:0] ptr, dat, got, pec;
   logic       ce_en        = 1'b1;
   int         fails        = 0;
   int         cmp_count    = 0;
   int         cyc          = 0;
   int         seed         = 32'hABC4;
   always #20 mclk_i = ~mclk_i;
   // pull-up: the line is low while either side pulls it
   assign sda_w = sda_m & (sda_oe_n | sda_d);
   smbus_slave #(.TIMEOUT_CYCLES(TO_CYC)) smbus_slave_i (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_en), .scl_i(scl_m),
      .sda_i(sda_w), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .alert_o(alert_d),
      .alert_oe_n_o(alert_oe_n), .alert_cond_i(alert_cond_i), .status_i(status_i));
   smbus_master_model smbus_master_model_i (
      .mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // crc-8, x8 + x2 + x + 1, msb first
   function automatic logic [7:0] pec8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      end
      return r;
   endfunction
   task automatic conclude();
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] b, input logic e);
      logic a;
      smbus_master_model_i.put_byte(b, a);
      chk("ack", {7'h00, e}, {7'h00, a});
   endtask
   task automatic rd(input logic [7:0] e);
      smbus_master_model_i.start();
      put(8'h99, 1'b0);
      smbus_master_model_i.get_byte(1'b1, got);
      chk("rdata", e, got);
      smbus_master_model_i.stop();
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      smbus_master_model_i.start();
      put(8'h98, 1'b0);
      put(p, 1'b0);
      put(d, 1'b0);
      smbus_master_model_i.stop();
   endtask
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         fails++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk_i);
      chk("rst_sda", 8'h01, {7'h00, sda_oe_n});
      chk("rst_alert", 8'h01, {7'h00, alert_oe_n});
      #1 rstn_i = 1'b1;
      repeat (4) @(posedge mclk_i);
      rd(8'h00);
      // stall with scl low while slave drives a 0
      smbus_master_model_i.start();
      put(8'h99, 1'b0);
      // a frozen core must not count towards the timeout
      ce_en = 1'b0;
      smbus_master_model_i.hold(TO_CYC + 50);
      chk("ce_freeze", 8'h00, {7'h00, sda_oe_n});
      ce_en = 1'b1;
      smbus_master_model_i.hold(TO_CYC + 50);
      chk("to_release", 8'h01, {7'h00, sda_oe_n});
      smbus_master_model_i.stop();
      wr(CONFIG_ONE_OFS, 8'h20);
      smbus_master_model_i.start();
      put(8'h99, 1'b0);
      smbus_master_model_i.hold(TO_CYC + 50);
      chk("to_off", 8'h00, {7'h00, sda_oe_n});
      smbus_master_model_i.get_byte(1'b1, got);
      chk("config_one", 8'h20, got);
      smbus_master_model_i.stop();
      for (int i = 0; i < 6; i++) begin
         ptr = {2'b01, 6'($random(seed))};
         dat = 8'($random(seed));
         wr(ptr, dat);
         smbus_master_model_i.start();
         put(8'h98, 1'b0);
         put(ptr, 1'b0);
         rd(dat);
         rd(dat);
      end
      // pec: matching byte acked, a fourth byte and a wrong pec refused
      pec = pec8(pec8(pec8(8'h00, 8'h98), ptr), dat);
      smbus_master_model_i.start();
      put(8'h98, 1'b0);
      put(ptr, 1'b0);
      put(dat, 1'b0);
      put(pec, 1'b0);
      put(pec, 1'b1);
      smbus_master_model_i.stop();
      smbus_master_model_i.start();
      put(8'h98, 1'b0);
      put(ptr, 1'b0);
      put(dat, 1'b0);
      put(~pec, 1'b1);
      smbus_master_model_i.stop();
      // read byte with the master asking for the pec
      smbus_master_model_i.start();
      put(8'h98, 1'b0);
      put(ptr, 1'b0);
      smbus_master_model_i.start();
      put(8'h99, 1'b0);
      smbus_master_model_i.get_byte(1'b0, got);
      chk("rdata_pec", dat, got);
      pec = pec8(pec8(pec8(pec8(8'h00, 8'h98), ptr), 8'h99), dat);
      smbus_master_model_i.get_byte(1'b1, got);
      chk("pec", pec, got);
      smbus_master_model_i.stop();
      smbus_master_model_i.start();
      put(8'h96, 1'b1);
      smbus_master_model_i.start();
      put(8'h19, 1'b1);
      smbus_master_model_i.stop();
      status_i = 8'($random(seed));
      @(posedge mclk_i);
      #1 alert_cond_i = 1'b1;
      @(posedge mclk_i);
      #1 alert_cond_i = 1'b0;
      @(posedge mclk_i);
      chk("alert_set", 8'h00, {7'h00, alert_oe_n});
      chk("alert_pin", 8'h00, {7'h00, alert_d});
      // a rival with a lower address wins the first alert response
      smbus_master_model_i.start();
      put(8'h19, 1'b0);
      dat = 8'h8F;
      for (int i = 7; i >= 0; i--) begin
         smbus_master_model_i.bit_cyc(dat[i], got[i]);
      end
      chk("arb_rival", dat, got);
      smbus_master_model_i.bit_cyc(1'b1, got[0]);
      smbus_master_model_i.stop();
      chk("alert_keep", 8'h00, {7'h00, alert_oe_n});
      smbus_master_model_i.start();
      put(8'h19, 1'b0);
      smbus_master_model_i.get_byte(1'b1, got);
      chk("ara_addr", {OWN_ADDR, 1'b0}, got);
      smbus_master_model_i.stop();
      chk("alert_hold", 8'h00, {7'h00, alert_oe_n});
      smbus_master_model_i.start();
      put(8'h98, 1'b0);
      put(STATUS_OFS, 1'b0);
      rd(status_i);
      chk("alert_clr", 8'h01, {7'h00, alert_oe_n});
      conclude();
   end
endmodule
